// [hdl/gpio_peripheral_pin_mux.sv]
// Pin multiplexer between GPIO logic and peripheral signals on ports A to D.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Port A bit 4 selects pulse output 4, fault 1 or timer 2.
// - Port A bit 5 selects pulse output 5, fault 2 or timer 3.
// - Port B bit 0 carries SPI clock or I2C clock; GPIO after reset.
// - Port B bit 1 carries SPI slave select or I2C data; GPIO after reset.
// - Port B bit 2 carries SPI MISO or timer 2; GPIO after reset.
// - Port B bit 3 carries SPI MOSI or timer 3; GPIO after reset.
// - Port B bit 4 carries timer 0 or clock output; GPIO after reset.
// - Port B bit 5 carries timer 1 or fault 3; GPIO after reset.
// - Port B bit 6 carries serial receive or I2C data; GPIO after reset.
// - Clock-block enable turns port B bit 6 into clock input, ignoring select.
// - Port B bit 7 carries serial transmit or I2C clock; GPIO after reset.
// - Reset: A and B GPIO except A7 reset input, C analog, D JTAG.
// - Port C bits 3 and 7 are never driven nor observed.
module gpio_peripheral_pin_mux (
  input  wire logic        mclk,         // System clock, 100 MHz.
  input  wire logic        resetn,       // Asynchronous reset, active low.
  input  wire logic        cfgWr,        // Load the four enable words.
  input  wire logic [7:0]  enAIn,        // Port A peripheral enables.
  input  wire logic [7:0]  enBIn,        // Port B peripheral enables.
  input  wire logic [7:0]  enCIn,        // Port C peripheral enables.
  input  wire logic [3:0]  enDIn,        // Port D peripheral enables.
  input  wire logic        selWr,        // Load the select register.
  input  wire logic [11:0] selIn,        // New select register value.
  input  wire logic        clkInEn,      // Clock-block enable of clock input.
  input  wire logic [7:0]  gpioOutA,     // GPIO data, port A.
  input  wire logic [7:0]  gpioDirA,     // GPIO direction, port A.
  input  wire logic [7:0]  gpioOutB,     // GPIO data, port B.
  input  wire logic [7:0]  gpioDirB,     // GPIO direction, port B.
  input  wire logic [7:0]  gpioOutC,     // GPIO data, port C.
  input  wire logic [7:0]  gpioDirC,     // GPIO direction, port C.
  input  wire logic [3:0]  gpioOutD,     // GPIO data, port D.
  input  wire logic [3:0]  gpioDirD,     // GPIO direction, port D.
  input  wire logic [7:0]  padInA,       // Pin levels, port A.
  input  wire logic [7:0]  padInB,       // Pin levels, port B.
  input  wire logic [7:0]  padInC,       // Pin levels, port C.
  input  wire logic [3:0]  padInD,       // Pin levels, port D.
  input  wire logic [5:0]  pulseOut,     // Pulse-width outputs 0 to 5.
  input  wire logic [3:0]  timerOut,     // Timer channel outputs.
  input  wire logic [3:0]  timerOe,      // Timer channel output enables.
  input  wire logic [3:0]  spiOut,       // SPI sclk, ss, miso, mosi out.
  input  wire logic [3:0]  spiOe,        // SPI output enables, same order.
  input  wire logic        i2cSclOut,    // I2C clock out.
  input  wire logic        i2cSclOe,     // I2C clock enable.
  input  wire logic        i2cSdaOut,    // I2C data out.
  input  wire logic        i2cSdaOe,     // I2C data enable.
  input  wire logic        txd,          // Serial transmit data.
  input  wire logic        clockOutput,  // Internal clock to bring out.
  input  wire logic        tdoOut,       // JTAG data out.
  input  wire logic        tdoOe,        // JTAG data out enable.
  output logic [7:0]       padOutA,      // Pin drive value, port A.
  output logic [7:0]       padOeA,       // Pin drive enable, port A.
  output logic [7:0]       padOutB,      // Pin drive value, port B.
  output logic [7:0]       padOeB,       // Pin drive enable, port B.
  output logic [7:0]       padOutC,      // Pin drive value, port C.
  output logic [7:0]       padOeC,       // Pin drive enable, port C.
  output logic [3:0]       padOutD,      // Pin drive value, port D.
  output logic [3:0]       padOeD,       // Pin drive enable, port D.
  output logic [7:0]       gpioInA,      // Pin levels to GPIO, port A.
  output logic [7:0]       gpioInB,      // Pin levels to GPIO, port B.
  output logic [7:0]       gpioInC,      // Pin levels to GPIO, port C.
  output logic [3:0]       gpioInD,      // Pin levels to GPIO, port D.
  output logic [3:0]       faultIn,      // Fault inputs 0 to 3.
  output logic [3:0]       timerIn,      // Timer channel inputs.
  output logic [3:0]       spiIn,        // SPI sclk, ss, miso, mosi in.
  output logic             i2cSclIn,     // I2C clock in.
  output logic             i2cSdaIn,     // I2C data in.
  output logic             rxd,          // Serial receive data.
  output logic             extClkIn,     // External clock input.
  output logic             resetPinN,    // Reset pin level, active low.
  output logic [7:0]       analogConn,   // Analog input switch closed.
  output logic [3:0]       jtagIn,       // tdi, unused, tck, tms.
  output logic [11:0]      selState,     // Select register readback.
  output logic [27:0]      enState       // Enables readback, D C B A.
);
  logic [7:0]  enA_q, enB_q, enC_q;
  logic [3:0]  enD_q;
  logic [11:0] peripheralSelectReg_q;
  logic [7:0]  oA, eA, oB, eB, oC, eC;
  logic [3:0]  oD, eD;
  logic [3:0]  faultD, timerD, spiD, jtagD;
  logic        sclD, sdaD, rxdD, clkD, rstD;
  logic [7:0]  anaD;
  logic [1:0]  selA4, selA5;
  logic [11:0] s;

  assign s     = peripheralSelectReg_q;
  assign selA4 = s[pin_mux_pkg::SEL_A4 +: 2];
  assign selA5 = s[pin_mux_pkg::SEL_A5 +: 2];

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      enA_q <= pin_mux_pkg::EN_A_RESET;
      enB_q <= pin_mux_pkg::EN_B_RESET;
      enC_q <= pin_mux_pkg::EN_C_RESET;
      enD_q <= pin_mux_pkg::EN_D_RESET;
    end else if (cfgWr) begin
      enA_q <= enAIn;
      enB_q <= enBIn;
      enC_q <= enCIn;
      enD_q <= enDIn;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      peripheralSelectReg_q <= pin_mux_pkg::SEL_RESET;
    end else if (selWr) begin
      peripheralSelectReg_q <= selIn;
    end
  end

  // GPIO drives every bonded pin whose enable is clear; each enabled pin, and B6 under clkInEn, overrides below.
  always_comb begin
    oA = gpioOutA;
    eA = gpioDirA;
    oB = gpioOutB;
    eB = gpioDirB;
    oC = gpioOutC & pin_mux_pkg::C_BONDED;
    eC = gpioDirC & pin_mux_pkg::C_BONDED;
    oD = gpioOutD;
    eD = gpioDirD;
    faultD = 4'h0;
    timerD = 4'h0;
    spiD = 4'h2;
    sclD = 1'b1;
    sdaD = 1'b1;
    rxdD = 1'b1;
    clkD = 1'b0;
    rstD = 1'b1;
    jtagD = 4'h9;
    anaD = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (enA_q[i]) begin
        oA[i] = pulseOut[i];
        eA[i] = 1'b1;
      end
    end
    if (enA_q[4]) begin
      unique case (selA4)
        pin_mux_pkg::A_FAULT: begin
          eA[4] = 1'b0;
          faultD[1] = padInA[4];
        end
        pin_mux_pkg::A_TIMER: begin
          oA[4] = timerOut[2];
          eA[4] = timerOe[2];
          timerD[2] = padInA[4];
        end
        default: begin
          oA[4] = pulseOut[4];
          eA[4] = 1'b1;
        end
      endcase
    end
    if (enA_q[5]) begin
      unique case (selA5)
        pin_mux_pkg::A_FAULT: begin
          eA[5] = 1'b0;
          faultD[2] = padInA[5];
        end
        pin_mux_pkg::A_TIMER: begin
          oA[5] = timerOut[3];
          eA[5] = timerOe[3];
          timerD[3] = padInA[5];
        end
        default: begin
          oA[5] = pulseOut[5];
          eA[5] = 1'b1;
        end
      endcase
    end
    if (enA_q[6]) begin
      eA[6] = 1'b0;
      faultD[0] = padInA[6];
    end
    if (enA_q[7]) begin
      eA[7] = 1'b0;
      rstD = padInA[7];
    end
    // A timer channel or I2C line enabled on two pins at once listens to port B.
    if (enB_q[0]) begin
      if (s[pin_mux_pkg::SEL_B0]) begin
        oB[0] = i2cSclOut;
        eB[0] = i2cSclOe;
        sclD = padInB[0];
      end else begin
        oB[0] = spiOut[0];
        eB[0] = spiOe[0];
        spiD[0] = padInB[0];
      end
    end
    if (enB_q[1]) begin
      if (s[pin_mux_pkg::SEL_B1]) begin
        oB[1] = i2cSdaOut;
        eB[1] = i2cSdaOe;
        sdaD = padInB[1];
      end else begin
        oB[1] = spiOut[1];
        eB[1] = spiOe[1];
        spiD[1] = padInB[1];
      end
    end
    for (int i = 2; i < 4; i++) begin
      if (enB_q[i]) begin
        if (s[pin_mux_pkg::SEL_B2 + i - 2]) begin
          oB[i] = timerOut[i];
          eB[i] = timerOe[i];
          timerD[i] = padInB[i];
        end else begin
          oB[i] = spiOut[i];
          eB[i] = spiOe[i];
          spiD[i] = padInB[i];
        end
      end
    end
    if (enB_q[4]) begin
      eB[4] = s[pin_mux_pkg::SEL_B4] | timerOe[0];
      oB[4] = s[pin_mux_pkg::SEL_B4] ? clockOutput : timerOut[0];
      if (!s[pin_mux_pkg::SEL_B4]) begin
        timerD[0] = padInB[4];
      end
    end
    if (enB_q[5]) begin
      if (s[pin_mux_pkg::SEL_B5]) begin
        eB[5] = 1'b0;
        faultD[3] = padInB[5];
      end else begin
        oB[5] = timerOut[1];
        eB[5] = timerOe[1];
        timerD[1] = padInB[5];
      end
    end
    // The clock input wins over every other use so the oscillator is never driven.
    if (clkInEn) begin
      eB[6] = 1'b0;
      clkD = padInB[6];
    end else if (enB_q[6]) begin
      if (s[pin_mux_pkg::SEL_B6]) begin
        oB[6] = i2cSdaOut;
        eB[6] = i2cSdaOe;
        sdaD = padInB[6];
      end else begin
        eB[6] = 1'b0;
        rxdD = padInB[6];
      end
    end
    if (enB_q[7]) begin
      if (s[pin_mux_pkg::SEL_B7]) begin
        oB[7] = i2cSclOut;
        eB[7] = i2cSclOe;
        sclD = padInB[7];
      end else begin
        oB[7] = txd;
        eB[7] = 1'b1;
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (enC_q[i]) begin
        eC[i] = 1'b0;
        anaD[i] = pin_mux_pkg::C_BONDED[i];
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (enD_q[i]) begin
        eD[i] = (i == 1) ? tdoOe : 1'b0;
        oD[i] = (i == 1) ? tdoOut : 1'b0;
        jtagD[i] = (i == 1) ? 1'b0 : padInD[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {padOutA, padOeA, padOutB, padOeB} <= 32'h0000_0000;
      {padOutC, padOeC, padOutD, padOeD} <= 24'h00_0000;
    end else begin
      {padOutA, padOeA, padOutB, padOeB} <= {oA, eA, oB, eB};
      {padOutC, padOeC, padOutD, padOeD} <= {oC, eC, oD, eD};
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {faultIn, timerIn, jtagIn} <= 12'h009;
      {spiIn, i2cSclIn, i2cSdaIn, rxd} <= 7'h17;
      {extClkIn, resetPinN} <= 2'h1;
      analogConn <= pin_mux_pkg::EN_C_RESET & pin_mux_pkg::C_BONDED;
    end else begin
      {faultIn, timerIn, jtagIn} <= {faultD, timerD, jtagD};
      {spiIn, i2cSclIn, i2cSdaIn, rxd} <= {spiD, sclD, sdaD, rxdD};
      {extClkIn, resetPinN, analogConn} <= {clkD, rstD, anaD};
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {gpioInA, gpioInB, gpioInC, gpioInD} <= 28'h000_0000;
      selState <= pin_mux_pkg::SEL_RESET;
      enState <= 28'h000_0000;
    end else begin
      gpioInA <= padInA;
      gpioInB <= padInB;
      gpioInC <= padInC & pin_mux_pkg::C_BONDED;
      gpioInD <= padInD;
      selState <= peripheralSelectReg_q;
      enState <= {enD_q, enC_q, enB_q, enA_q};
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  reset_enables_a: assert property ($rose(resetn) |-> enA_q == 8'h80 && enB_q == 8'h00 && enC_q == 8'hff && enD_q == 4'hf) else $error("enables not at reset values");
  a4_fault_a: assert property (enA_q[4] && selA4 == 2'h1 && !cfgWr |=> !padOeA[4] && faultIn[1] == $past(padInA[4])) else $error("A4 fault path wrong");
  a5_timer_a: assert property (enA_q[5] && selA5 == 2'h2 |=> padOutA[5] == $past(timerOut[3]) && padOeA[5] == $past(timerOe[3])) else $error("A5 timer path wrong");
  b0_i2c_a: assert property (enB_q[0] && s[4] |=> padOutB[0] == $past(i2cSclOut) && padOeB[0] == $past(i2cSclOe)) else $error("B0 I2C clock path wrong");
  b1_spi_a: assert property (enB_q[1] && !s[5] |=> spiIn[1] == $past(padInB[1])) else $error("B1 slave select path wrong");
  b4_clock_a: assert property (enB_q[4] && s[8] |=> padOeB[4] && padOutB[4] == $past(clockOutput)) else $error("B4 clock output wrong");
  b6_external_clock_input_a: assert property (clkInEn |=> !padOeB[6] && extClkIn == $past(padInB[6])) else $error("B6 clock input wrong");
  b7_txd_a: assert property (enB_q[7] && !s[11] |=> padOeB[7] && padOutB[7] == $past(txd)) else $error("B7 transmit path wrong");
  c_unbonded_a: assert property (!padOeC[3] && !padOeC[7] && !gpioInC[3] && !gpioInC[7] && !analogConn[3] && !analogConn[7]) else $error("unbonded C pin used");
  gpio_owner_a: assert property (!enB_q[2] ##1 !enB_q[2] |-> padOeB[2] == $past(gpioDirB[2]) && padOutB[2] == $past(gpioOutB[2])) else $error("GPIO not driving B2");
  b5_fault_a: assert property (enB_q[5] && s[9] |=> !padOeB[5] && faultIn[3] == $past(padInB[5])) else $error("B5 fault path wrong");
  pwm_pin_a: assert property (enA_q[0] |=> padOeA[0] && padOutA[0] == $past(pulseOut[0])) else $error("A0 pulse path wrong");

  a4_timer_c: cover property (enA_q[4] && selA4 == 2'h2 ##1 timerIn[2]);
  b6_sda_c: cover property (!clkInEn && enB_q[6] && s[10] ##1 !i2cSdaIn);
  external_clock_input_c: cover property (clkInEn && !enB_q[6] ##1 extClkIn);
  cfg_load_c: cover property (cfgWr ##1 enA_q == 8'h00);
endmodule // gpio_peripheral_pin_mux
`default_nettype wire

// [hdl/pin_mux_pkg.sv]
// Field layout and reset values shared by the pin multiplexer.
package pin_mux_pkg;
  localparam int SEL_W = 12;
  // Field positions in the peripheral select register.
  localparam int SEL_A4 = 0;
  localparam int SEL_A5 = 2;
  localparam int SEL_B0 = 4;
  localparam int SEL_B1 = 5;
  localparam int SEL_B2 = 6;
  localparam int SEL_B3 = 7;
  localparam int SEL_B4 = 8;
  localparam int SEL_B5 = 9;
  localparam int SEL_B6 = 10;
  localparam int SEL_B7 = 11;
  // Codes of the three-way fields; the unused code falls back to the pulse output.
  localparam logic [1:0] A_PULSE = 2'h0;
  localparam logic [1:0] A_FAULT = 2'h1;
  localparam logic [1:0] A_TIMER = 2'h2;
  localparam logic [SEL_W-1:0] SEL_RESET = 12'h000;
  localparam logic [7:0] EN_A_RESET = 8'h80;
  localparam logic [7:0] EN_B_RESET = 8'h00;
  localparam logic [7:0] EN_C_RESET = 8'hff;
  localparam logic [3:0] EN_D_RESET = 4'hf;
  // Port C bits 3 and 7 have no package pin.
  localparam logic [7:0] C_BONDED = 8'h77;
endpackage

// [verification/periph_model.sv]
// Behavioural model of the on-chip peripherals that drive the multiplexer.
`timescale 1ns/1ps
`default_nettype none
module periph_model (
  input  wire logic [15:0] drv,          // Requested levels from the bench.
  output logic      [5:0]  pulseOut,     // Pulse-width outputs.
  output logic      [3:0]  timerOut,     // Timer outputs.
  output logic      [3:0]  timerOe,      // Timer output enables.
  output logic      [3:0]  spiOut,       // SPI outputs.
  output logic      [3:0]  spiOe,        // SPI output enables.
  output logic             i2cSclOut,    // I2C clock out.
  output logic             i2cSclOe,     // I2C clock enable.
  output logic             i2cSdaOut,    // I2C data out.
  output logic             i2cSdaOe,     // I2C data enable.
  output logic             txd,          // Serial transmit.
  output logic             clockOutput,  // Internal clock.
  output logic             tdoOut,       // JTAG data out.
  output logic             tdoOe         // JTAG data out enable.
);
  // The I2C controller is idle and has released both open-drain lines.
  assign pulseOut    = drv[5:0];
  assign timerOut    = drv[9:6];
  assign spiOut      = drv[13:10];
  assign clockOutput = drv[14];
  assign txd         = drv[15];
  assign timerOe     = 4'hf;
  assign spiOe       = 4'hf;
  assign i2cSclOut   = 1'h0;
  assign i2cSclOe    = 1'h0;
  assign i2cSdaOut   = 1'h0;
  assign i2cSdaOe    = 1'h0;
  assign tdoOut      = drv[0];
  assign tdoOe       = 1'h1;
endmodule // periph_model
`default_nettype wire

// [verification/tb_gpio_peripheral_pin_mux.sv]
// Self-checking testbench of the GPIO and peripheral pin multiplexer.
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_peripheral_pin_mux;
  typedef struct packed {
    logic [15:0] en;
    logic [11:0] sel;
    logic [15:0] drv;
    logic [7:0]  oeA, outA, oeB, outB;
  } row_t;
  logic        mclk, resetn, cfgWr, selWr, clkInEn;
  logic [7:0]  enAIn, enBIn, enCIn, gpioOutA, gpioDirA, gpioOutB, gpioDirB, gpioOutC, gpioDirC;
  logic [7:0]  padInA, padInB, padInC, padOutA, padOeA, padOutB, padOeB, padOutC, padOeC;
  logic [7:0]  gpioInA, gpioInB, gpioInC, analogConn;
  logic [3:0]  enDIn, gpioOutD, gpioDirD, padInD, padOutD, padOeD, gpioInD, jtagIn;
  logic [3:0]  timerOut, timerOe, spiOut, spiOe, faultIn, timerIn, spiIn;
  logic [5:0]  pulseOut;
  logic        i2cSclOut, i2cSclOe, i2cSdaOut, i2cSdaOe, txd, clockOutput, tdoOut, tdoOe;
  logic        i2cSclIn, i2cSdaIn, rxd, extClkIn, resetPinN;
  logic [11:0] selIn, selState;
  logic [27:0] enState;
  logic [15:0] drv;
  int          fails, n_tests;
  row_t        rows [5];

  periph_model periph_model_i (.drv, .pulseOut, .timerOut, .timerOe, .spiOut, .spiOe,
    .i2cSclOut, .i2cSclOe, .i2cSdaOut, .i2cSdaOe, .txd, .clockOutput, .tdoOut, .tdoOe);

  gpio_peripheral_pin_mux gpio_peripheral_pin_mux_i (.mclk, .resetn, .cfgWr, .enAIn, .enBIn,
    .enCIn, .enDIn, .selWr, .selIn, .clkInEn, .gpioOutA, .gpioDirA, .gpioOutB, .gpioDirB,
    .gpioOutC, .gpioDirC, .gpioOutD, .gpioDirD, .padInA, .padInB, .padInC, .padInD,
    .pulseOut, .timerOut, .timerOe, .spiOut, .spiOe, .i2cSclOut, .i2cSclOe, .i2cSdaOut,
    .i2cSdaOe, .txd, .clockOutput, .tdoOut, .tdoOe, .padOutA, .padOeA, .padOutB, .padOeB,
    .padOutC, .padOeC, .padOutD, .padOeD, .gpioInA, .gpioInB, .gpioInC, .gpioInD, .faultIn,
    .timerIn, .spiIn, .i2cSclIn, .i2cSdaIn, .rxd, .extClkIn, .resetPinN, .analogConn,
    .jtagIn, .selState, .enState);

  always #5 mclk = ~mclk;

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Loads enables and select together; outputs settle one edge after the load edge.
  task automatic load(input logic [15:0] en, input logic [11:0] sel);
    enAIn = en[7:0];
    enBIn = en[15:8];
    selIn = sel;
    cfgWr = 1'h1;
    selWr = 1'h1;
    step(1);
    cfgWr = 1'h0;
    selWr = 1'h0;
    step(3);
  endtask

  task automatic wrap_up();
    $display("Counts: fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (2000) @(posedge mclk);
    fails++;
    wrap_up();
  end

  initial begin
    mclk = 1'h0; resetn = 1'h0; cfgWr = 1'h0; selWr = 1'h0; clkInEn = 1'h0;
    enAIn = 8'h80; enBIn = 8'h00; enCIn = 8'hff; enDIn = 4'hf; selIn = 12'h000;
    gpioOutA = 8'h3c; gpioDirA = 8'hf0; gpioOutB = 8'hc3; gpioDirB = 8'h0f;
    gpioOutC = 8'hff; gpioDirC = 8'hff; gpioOutD = 4'h0; gpioDirD = 4'hf;
    padInA = 8'h10; padInB = 8'h00; padInC = 8'hff; padInD = 4'hd; drv = 16'h656a;
    fails = 0; n_tests = 0;
    // Columns: enables {B,A}, select, peripheral drive, then expected A and B pins.
    rows[0] = '{16'hffff, 12'h000, 16'h656a, 8'h3f, 8'h2a, 8'hbf, 8'h19};
    rows[1] = '{16'hffff, 12'h3c9, 16'h656a, 8'h2f, 8'h0a, 8'h9f, 8'h15};
    rows[2] = '{16'hffff, 12'h00e, 16'h9a95, 8'h3f, 8'h05, 8'hbf, 8'ha6};
    rows[3] = '{16'h0000, 12'h000, 16'h656a, 8'hf0, 8'h30, 8'h0f, 8'h03};
    rows[4] = '{16'hf00f, 12'h000, 16'h656a, 8'hff, 8'h3a, 8'hbf, 8'h13};
    step(20);
    resetn = 1'h1;
    step(3);
    chk(enState, 28'hfff0080);
    chk(selState, 12'h000);
    chk(padOeA, 8'h70);
    chk(padOeB, 8'h0f);
    chk({padOeC, padOeD}, 12'h002);
    chk({analogConn, jtagIn}, 12'h77d);
    chk(resetPinN, 1'h0);
    foreach (rows[i]) begin
      drv = rows[i].drv;
      load(rows[i].en, rows[i].sel);
      chk(padOeA, rows[i].oeA);
      chk(padOutA & rows[i].oeA, rows[i].outA);
      chk(padOeB, rows[i].oeB);
      chk(padOutB & rows[i].oeB, rows[i].outB);
      chk(padOutD[1], rows[i].drv[0]);
    end
    // Unbonded analog bits must stay quiet even when GPIO asks to drive them.
    enCIn = 8'h00;
    load(16'hffff, 12'h000);
    chk(padOeC, 8'h77);
    chk(gpioInC, 8'h77);
    chk(padOutC, 8'h77);
    enCIn = 8'hff;
    padInA = 8'h30;
    load(16'hffff, 12'h035);
    chk(faultIn[2:1], 2'h3);
    chk({i2cSclIn, i2cSdaIn, rxd}, 3'h0);
    padInB = 8'h3f;
    load(16'hffff, 12'hc30);
    chk({i2cSclIn, i2cSdaIn}, 2'h0);
    chk(timerIn[1], 1'h1);
    // The clock input must win although the pin is not enabled for peripherals.
    clkInEn = 1'h1;
    load(16'h0080, 12'h000);
    padInB = 8'h40;
    step(2);
    chk({extClkIn, padOeB[6]}, 2'h2);
    chk({gpioInA, gpioInB, gpioInD}, 20'h3040d);
    padInB = 8'h00;
    step(2);
    chk(extClkIn, 1'h0);
    // A second reset in mid-run must bring every path back to its power-up state.
    clkInEn = 1'h0;
    resetn = 1'h0;
    step(2);
    chk(enState, 28'h000_0000);
    chk({padOeA, padOeB, padOeD}, 20'h0_0000);
    chk({spiIn, i2cSclIn, i2cSdaIn, rxd, resetPinN, extClkIn}, 9'h05e);
    chk({analogConn, jtagIn}, 12'h779);
    resetn = 1'h1;
    step(3);
    chk(enState, 28'hfff0080);
    chk({selState, padOeB}, 20'h0000f);
    wrap_up();
  end
endmodule // tb_gpio_peripheral_pin_mux
`default_nettype wire
